// ---- bench/sic_card_model.sv ----
`timescale 1ns/1ps
module sic_card_model
  import sic_pkg::*;
(
  // bench control
  input wire logic clk,
  input wire logic busy_req,
  input wire logic touch_req,
  input wire logic host_req,
  // card pins
  output sic_pkg::sic_link_in_t link_in
);
  initial link_in = '0;
  // pins move off the edge, as an unrelated card would
  always @(posedge clk) begin
    link_in.card_busy <= #7 busy_req;
    link_in.card_access <= #7 busy_req & touch_req;
    link_in.host_request <= #7 host_req;
  end
endmodule : sic_card_model

// ---- bench/sic_checker.sv ----
`timescale 1ns/1ps
module sic_checker
  import sic_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // register port
  input wire sic_pkg::sic_bus_req_t bus_req,
  input wire logic [31:0] rdata,
  // card side
  input wire sic_pkg::sic_link_in_t link_in,
  input wire logic card_clk_stop,
  input wire logic card_clk_slow,
  input wire logic card_clk_en,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // shadow of the enable bit, as software last wrote it
  logic en_q;
  always_ff @(posedge clk) begin
    if (!reset_n) en_q <= 1'b0;
    else if (ce && bus_req.wr && bus_req.addr == SIC_PM_OFFSET) en_q <= bus_req.wdata[SIC_ENABLE_BIT];
  end
  sequence s_busy_held;
    (ce && link_in.card_busy) [*5];
  endsequence
  sequence s_slow_pulse;
    ce && card_clk_slow && card_clk_en ##1 card_clk_slow;
  endsequence
  chk_rd_idle_zero: assert property (ce && !bus_req.rd |=> rdata == 32'h0)
    else $error("rdata not zero outside read");
  chk_rsvd_bits_zero: assert property (ce && bus_req.rd && bus_req.addr == SIC_PM_OFFSET |=>
    rdata[31:26] == 6'h0 && rdata[23:17] == 7'h0 && rdata[15:1] == 15'h0)
    else $error("reserved bits set");
  chk_stop_slow_excl: assert property (!(card_clk_stop && card_clk_slow))
    else $error("stop and slow together");
  chk_stop_no_edge: assert property (card_clk_stop |-> !card_clk_en)
    else $error("edge passed while stopped");
  chk_slow_one_pulse: assert property (s_slow_pulse |-> !card_clk_en)
    else $error("slow pulse too long");
  chk_normal_runs: assert property (!card_clk_stop && !card_clk_slow |-> card_clk_en)
    else $error("clock gated in normal mode");
  chk_busy_restores: assert property (s_busy_held |-> !card_clk_stop && !card_clk_slow)
    else $error("busy card left without clock");
  chk_disabled_idle: assert property (!en_q [*3] |-> !card_clk_stop && !card_clk_slow)
    else $error("clock altered while disabled");
  chk_idle_only: assert property ($rose(card_clk_stop) |->
    $past(link_in.card_busy, 2) == 1'b0 && $past(link_in.host_request, 2) == 1'b0)
    else $error("stop without idle");
endmodule : sic_checker
bind sic_top sic_checker chk (.clk(clk), .reset_n(reset_n), .ce(ce), .bus_req(bus_req),
  .rdata(rdata), .link_in(link_in), .card_clk_stop(card_clk_stop),
  .card_clk_slow(card_clk_slow), .card_clk_en(card_clk_en), .irq(irq));

// ---- bench/tb_sic_top.sv ----
`timescale 1ns/1ps
module tb_sic_top;
  import sic_pkg::*;
  logic clk = 0, reset_n = 0, ce = 1, busy = 1, touch = 0, host = 0;
  sic_bus_req_t req = '0;
  sic_link_in_t link_in;
  logic [31:0] rdata;
  logic stp, slw, cen, irq;
  int err_total = 0, n_tests = 0, d0, d1, k;
  always #50 clk = ~clk;
  sic_card_model card (.clk(clk), .busy_req(busy), .touch_req(touch), .host_req(host),
    .link_in(link_in));
  sic_top dut (.clk(clk), .reset_n(reset_n), .ce(ce), .bus_req(req), .rdata(rdata),
    .link_in(link_in), .card_clk_stop(stp), .card_clk_slow(slw), .card_clk_en(cen), .irq(irq));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd
  // card goes quiet; count cycles until the clock is altered (40 = never)
  task automatic idle_time(output int n);
    @(posedge clk);
    busy <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (!(stp | slw) && n < 40);
  endtask : idle_time
  task automatic wake;
    @(posedge clk);
    busy <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask : wake
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    #300000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(SIC_PM_OFFSET, 32'h0);
    rd(8'h30, 32'h0);
    wr(SIC_PM_OFFSET, 32'hfffe_fffe);
    rd(SIC_PM_OFFSET, 32'h0);
    wr(SIC_PM_OFFSET, 32'h0000_0001);
    idle_time(k);
    check(k, 40);
    rd(SIC_PM_OFFSET, 32'h0000_0001);
    wake();
    wr(SIC_IRQ_MASK_OFFSET, 32'h2);
    wr(SIC_PM_OFFSET, 32'h0001_0000);
    idle_time(d0);
    check({stp, cen, irq}, 3'b101);
    rd(SIC_PM_OFFSET, 32'h0101_0000);
    wr(SIC_IRQ_STAT_OFFSET, 32'h7);
    #1 check(irq, 1'b0);
    touch <= 1'b1;
    wake();
    touch <= 1'b0;
    check({stp, cen}, 2'b01);
    repeat (4) @(posedge clk);
    rd(SIC_PM_OFFSET, 32'h0201_0000);
    rd(SIC_PM_OFFSET, 32'h0001_0000);
    host <= 1'b1;
    idle_time(k);
    check(k, 40);
    host <= 1'b0;
    idle_time(k);
    check(stp, 1'b1);
    wake();
    wr(SIC_PM_OFFSET, 32'h0001_0001);
    idle_time(k);
    check({stp, slw}, 2'b01);
    k = 0;
    repeat (32) begin
      @(posedge clk);
      #1 k += cen;
    end
    check(k, 2);
    rd(SIC_PM_OFFSET, 32'h0101_0001);
    wake();
    wr(SIC_PM_OFFSET, 32'h0001_0000);
    wr(SIC_SOCKCTL_OFFSET, 32'h80);
    idle_time(d1);
    check(d1 - d0 >= 7, 1);
    wr(SIC_PM_OFFSET, 32'h0);
    repeat (4) @(posedge clk);
    #1 check({stp, slw}, 2'b00);
    // a write while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(SIC_PM_OFFSET, 32'h0001_0001);
    ce <= 1'b1;
    rd(SIC_PM_OFFSET, 32'h0);
    final_report();
  end
endmodule : tb_sic_top

// ---- design/sic_clk_div.sv ----
`timescale 1ns/1ps
module sic_clk_div #(
  parameter int DIV = 16,
  parameter int CNT_W = 4
) (
  // clock
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // control
  input wire logic run,
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q == CNT_W'(DIV - 1)) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  assign tick = run && (cnt_q == CNT_W'(DIV - 1));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end
endmodule : sic_clk_div

// ---- design/sic_pkg.sv ----
package sic_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] SIC_PM_OFFSET = 8'h20;
  localparam logic [7:0] SIC_SOCKCTL_OFFSET = 8'h10;
  localparam logic [7:0] SIC_IRQ_STAT_OFFSET = 8'h40;
  localparam logic [7:0] SIC_IRQ_MASK_OFFSET = 8'h44;
  localparam logic [31:0] SIC_PM_RESET = 32'h0000_0000;
  localparam logic [31:0] SIC_SOCKCTL_RESET = 32'h0000_0000;
  localparam int SIC_TOUCHED_BIT = 25;
  localparam int SIC_ALTERED_BIT = 24;
  localparam int SIC_ENABLE_BIT = 16;
  localparam int SIC_SELECT_BIT = 0;
  localparam int SIC_STOPPOL_BIT = 7;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int SIC_EV_W = 3;
  localparam int SIC_EV_TOUCH = 0;
  localparam int SIC_EV_ALTER = 1;
  localparam int SIC_EV_RESTORE = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SIC_IDLE_CLOCKS = 8;
  localparam int SIC_SLOW_DIV = 16;
  localparam int SIC_CNT_W = 4;

  typedef enum logic [1:0] {
    SIC_RUN = 2'b00,
    SIC_IDLE_WAIT = 2'b01,
    SIC_ALTERED = 2'b11
  } sic_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sic_bus_req_t;

  typedef struct packed {
    logic card_access;
    logic card_busy;
    logic host_request;
  } sic_link_in_t;

endpackage : sic_pkg

// ---- design/sic_top.sv ----
`timescale 1ns/1ps
// Operation
// - card access sets bit 25; any read of the register clears it; here a card access in the same cycle keeps it set.
// - bit 24 read-only: 0 normal clock, 1 card clock altered.
// - bit 0 selection applies only while enable bit 16 is one.
// - enabled with selection 0: stop card clock during idle.
// - enabled with selection 1: slow card clock, divide by 16.
// - reserved bits 31-26, 23-17, 15-1 read zero, writes ignored.
// - register at offset 20h, resets to all zeros.
// - alter clock only while idle; restore on card or host activity.
// - with stop policy set, idle needs eight consecutive idle clocks.
module sic_top
  import sic_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // register port
  input wire sic_pkg::sic_bus_req_t bus_req,
  output logic [31:0] rdata,
  // card side, asynchronous pins
  input wire sic_pkg::sic_link_in_t link_in,
  // card clock control
  output logic card_clk_stop,
  output logic card_clk_slow,
  output logic card_clk_en,
  // interrupt
  output logic irq
);
  import sic_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sic_link_in_t sync1;
    sic_link_in_t sync2;
    logic enable;
    logic select;
    logic stop_policy;
    logic touched;
    logic altered;
    sic_state_t state;
    logic [SIC_CNT_W-1:0] idle_cnt;
    logic mode_slow;
    logic [SIC_EV_W-1:0] irq_stat;
    logic [SIC_EV_W-1:0] irq_mask;
    logic [31:0] rdata;
    logic clk_stop;
    logic clk_slow;
    logic clk_en;
    logic irq;
  } sic_regs_t;

  sic_regs_t s_q;
  sic_regs_t s_d;
  logic slow_tick;
  logic busy;
  logic rd_pm;
  logic [31:0] pm_view;
  logic [SIC_EV_W-1:0] ev;
  logic [SIC_EV_W-1:0] stat_next;

  // ----------------------------------------------------------------
  // slow clock divider
  // ----------------------------------------------------------------
  sic_clk_div #(
    .DIV(SIC_SLOW_DIV),
    .CNT_W(SIC_CNT_W)
  ) u_div (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .run(s_q.mode_slow && s_q.state == SIC_ALTERED),
    .tick(slow_tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    busy = s_q.sync2.card_access || s_q.sync2.card_busy || s_q.sync2.host_request;
    rd_pm = bus_req.rd && bus_req.addr == SIC_PM_OFFSET;
    pm_view = '0;
    pm_view[SIC_TOUCHED_BIT] = s_q.touched;
    pm_view[SIC_ALTERED_BIT] = s_q.altered;
    pm_view[SIC_ENABLE_BIT] = s_q.enable;
    pm_view[SIC_SELECT_BIT] = s_q.select;
    ev = '0;

    s_d.sync1 = link_in;
    s_d.sync2 = s_q.sync1;

    // register writes touch only the defined bits
    if (bus_req.wr && bus_req.addr == SIC_PM_OFFSET) begin
      s_d.enable = bus_req.wdata[SIC_ENABLE_BIT];
      s_d.select = bus_req.wdata[SIC_SELECT_BIT];
    end
    if (bus_req.wr && bus_req.addr == SIC_SOCKCTL_OFFSET) begin
      s_d.stop_policy = bus_req.wdata[SIC_STOPPOL_BIT];
    end
    if (bus_req.wr && bus_req.addr == SIC_IRQ_MASK_OFFSET) begin
      s_d.irq_mask = bus_req.wdata[SIC_EV_W-1:0];
    end

    // read data, one cycle later
    s_d.rdata = '0;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        SIC_PM_OFFSET: s_d.rdata = pm_view;
        SIC_SOCKCTL_OFFSET: s_d.rdata = {24'h0, s_q.stop_policy, 7'h0};
        SIC_IRQ_STAT_OFFSET: s_d.rdata = {29'h0, s_q.irq_stat};
        SIC_IRQ_MASK_OFFSET: s_d.rdata = {29'h0, s_q.irq_mask};
        default: s_d.rdata = '0;
      endcase
    end

    // access flag: read clears, a card access in the same cycle wins
    if (rd_pm) begin
      s_d.touched = 1'b0;
    end
    if (s_q.sync2.card_access) begin
      s_d.touched = 1'b1;
      ev[SIC_EV_TOUCH] = ~s_q.touched;
    end

    // clock-run control
    unique case (s_q.state)
      SIC_RUN: begin
        s_d.idle_cnt = '0;
        if (s_q.enable && !busy) begin
          if (s_q.stop_policy) begin
            s_d.state = SIC_IDLE_WAIT;
            s_d.idle_cnt = SIC_CNT_W'(1);
          end else begin
            s_d.state = SIC_ALTERED;
            s_d.mode_slow = s_q.select;
            ev[SIC_EV_ALTER] = 1'b1;
          end
        end
      end
      SIC_IDLE_WAIT: begin
        if (!s_q.enable || busy) begin
          s_d.state = SIC_RUN;
        end else if (s_q.idle_cnt == SIC_CNT_W'(SIC_IDLE_CLOCKS - 1)) begin
          s_d.state = SIC_ALTERED;
          s_d.mode_slow = s_q.select;
          ev[SIC_EV_ALTER] = 1'b1;
        end else begin
          s_d.idle_cnt = s_q.idle_cnt + SIC_CNT_W'(1);
        end
      end
      SIC_ALTERED: begin
        if (!s_q.enable || busy) begin
          s_d.state = SIC_RUN;
          ev[SIC_EV_RESTORE] = 1'b1;
        end
      end
      default: s_d.state = SIC_RUN;
    endcase

    s_d.altered = (s_d.state == SIC_ALTERED);
    s_d.clk_stop = s_d.altered && !s_d.mode_slow;
    s_d.clk_slow = s_d.altered && s_d.mode_slow;
    if (s_d.state != SIC_ALTERED) begin
      s_d.clk_en = 1'b1;
    end else if (s_d.mode_slow) begin
      s_d.clk_en = slow_tick;
    end else begin
      s_d.clk_en = 1'b0;
    end

    // sticky status, write one to clear, new event wins
    stat_next = s_q.irq_stat;
    if (bus_req.wr && bus_req.addr == SIC_IRQ_STAT_OFFSET) begin
      stat_next = stat_next & ~bus_req.wdata[SIC_EV_W-1:0];
    end
    s_d.irq_stat = stat_next | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.clk_en <= 1'b1;
      s_q.state <= SIC_RUN;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign card_clk_stop = s_q.clk_stop;
  assign card_clk_slow = s_q.clk_slow;
  assign card_clk_en = s_q.clk_en;
  assign irq = s_q.irq;
endmodule : sic_top
